// ===== inc/gcss_pkg.sv
// Constants, register map and state type for the global clock source select block
package gcss_pkg;

  // Structure counts
  localparam int NETS        = 16;
  localparam int SIDES       = 4;
  localparam int NETS_SIDE   = 4;
  localparam int PLLS        = 4;
  localparam int PLL_OUTS    = 3;
  localparam int DP_SIDE     = 3;
  localparam int CORNER_PINS = 2;
  localparam int REGIONS     = 3;
  localparam int REGION_W    = 6;
  localparam int BLOCK_CLKS  = 2;

  // Synchroniser vector layout
  localparam int SY_DED    = 0;
  localparam int SY_PLL    = 16;
  localparam int SY_DP     = 28;
  localparam int SY_CORNER = 40;
  localparam int SY_W      = 48;

  // Register byte offsets
  localparam logic [7:0] NET_CFG_BASE = 8'h00;
  localparam logic [7:0] CORNER_CFG   = 8'h40;
  localparam logic [7:0] PLL_CFG      = 8'h44;
  localparam logic [7:0] REGION_BASE  = 8'h48;
  localparam logic [7:0] BLOCK_CFG    = 8'h54;
  localparam logic [7:0] STATUS_ON    = 8'h58;
  localparam logic [7:0] STATUS_SEL   = 8'h5C;

  // Per-network configuration fields
  localparam int NC_PIN_A = 0;
  localparam int NC_PIN_B = 2;
  localparam int NC_PLL_A = 4;
  localparam int NC_PLL_B = 6;
  localparam int NC_DP    = 8;
  localparam int NC_INT   = 10;
  localparam int NC_MODE  = 12;
  localparam int NC_W     = 14;

  // Static source modes
  localparam logic [1:0] MODE_DYNAMIC  = 2'h0;
  localparam logic [1:0] MODE_DUAL     = 2'h1;
  localparam logic [1:0] MODE_INTERNAL = 2'h2;
  localparam logic [1:0] MODE_OFF      = 2'h3;

  // Dynamic select codes
  localparam logic [1:0] DSEL_PIN_A = 2'h0;
  localparam logic [1:0] DSEL_PIN_B = 2'h1;
  localparam logic [1:0] DSEL_PLL_A = 2'h2;
  localparam logic [1:0] DSEL_PLL_B = 2'h3;

  // Field positions in PLL and block registers
  localparam int PC_STATIC = 0;
  localparam int PC_MANUAL = 1;
  localparam int BK_W      = 3;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Reset values
  localparam logic [NC_W-1:0] NET_CFG_RST = 14'h0000;
  localparam logic [3:0]      CORNER_RST  = 4'h0;
  localparam logic [7:0]      PLL_RST     = 8'h00;
  localparam logic [23:0]     REGION_RST  = 24'h543210;
  localparam logic [5:0]      BLOCK_RST   = 6'h08;

  typedef struct packed {
    logic [SY_W-1:0]                 s1;
    logic [SY_W-1:0]                 s2;
    logic [NETS-1:0][NC_W-1:0]       net_cfg;
    logic [3:0]                      corner;
    logic [7:0]                      pll;
    logic [REGIONS-1:0][23:0]        region;
    logic [5:0]                      block_pick;
    logic [NETS-1:0]                 on;
    logic [NETS-1:0][1:0]            asel;
    logic [NETS-1:0]                 gnet;
    logic [PLLS-1:0]                 pll_ref;
    logic [REGIONS-1:0][REGION_W-1:0] rbus;
    logic [BLOCK_CLKS-1:0]           bclk;
    logic                            aw_have;
    logic                            w_have;
    logic [7:0]                      awaddr;
    logic [31:0]                     wdata;
    logic [3:0]                      wstrb;
    logic                            bvalid;
    logic [1:0]                      bresp;
    logic                            rvalid;
    logic [31:0]                     rdata;
    logic [1:0]                      rresp;
  } gcss_state_t;

endpackage : gcss_pkg

// ===== design/gcss_top.sv
// Global clock control blocks, regional clock buses and register slave
`timescale 1ns/1ns
// Functional notes
// - One control block per global network, sixteen in total, four per side.
// - Candidates: four side pins, three PLL outputs, four dual-purpose pins, four internal.
// - Six inputs reach selection: two pins, two PLL outputs, one dual-purpose, one internal.
// - Two-bit run-time select picks among two pins and two PLL outputs.
// - Dual-purpose and internal inputs are chosen only by static configuration.
// - Static settings load from configuration and freeze during user mode.
// - User logic enables or disables each network through an enable input.
// - Reference switch picks one of two pins, statically or by manual switchover.
// - Corner pins pass a per-corner mux; only one per corner feeds blocks.
// - Each control block drives only its own global network.
// - Global networks multiplex into six-bit regional buses for three region kinds.
// - Each logic array block picks two of the six row clocks.
// - Unused dedicated clock pins serve as plain logic inputs, captured in fabric.
module gcss_top
  import gcss_pkg::*;
(
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Pins and PLL outputs, asynchronous
  input  wire logic [15:0] dedicated_clock_pin,
  input  wire logic [11:0] pll_counter_out,
  input  wire logic [11:0] dual_purpose_clock_pin,
  input  wire logic [7:0]  corner_dual_purpose_pin,
  // User logic, same clock
  input  wire logic [15:0] internal_clock_source,
  input  wire logic [31:0] global_source_select,
  input  wire logic [15:0] global_clock_enable,
  input  wire logic [3:0]  pll_reference_switch,
  input  wire logic        user_mode,
  // Clock outputs
  output logic      [15:0] global_clock_net,
  output logic      [3:0]  pll_reference_clock,
  output logic      [5:0]  region_column_io_element,
  output logic      [5:0]  region_row,
  output logic      [5:0]  region_row_io_element,
  output logic      [1:0]  logic_array_block_clock,
  output logic      [15:0] general_pin_input,
  // AXI4-Lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic      [1:0]  s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic      [31:0] s_axi_rdata,
  output logic      [1:0]  s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  gcss_state_t q;
  gcss_state_t d;

  // Register map, one aligned word each, fields read back zero-padded:
  //   0x00 + 4n  network n: pin A, pin B, PLL A, PLL B, dual slot, internal, mode
  //   0x40       corner pick, one bit per corner
  //   0x44       reference switch: static level and manual enable per PLL
  //   0x48..0x50 regional buses: six four-bit network indices each
  //   0x54       block clock picks, three bits each
  //   0x58       gate state and user mode, read only
  //   0x5C       applied dynamic selects, read only
  // Static words refuse writes in user mode, standing in for a loaded image
  // Latency: write answer one cycle after the later of address and data,
  //   read answer one cycle after the address
  // Clock path: pin to network takes three flops, two of them synchroniser;
  //   regional buses add one, block clocks one more
  // Sources are sampled levels, so a source above half of aclk aliases;
  //   the trade keeps every clock output a plain flip-flop

  // Scratch values for the combinational pass
  logic [3:0]  pins;
  logic [2:0]  plls;
  logic [3:0]  dps;
  logic [3:0]  ints;
  logic        cur;
  logic        nxt;
  logic        sw;
  logic [3:0]  gsel;
  logic [2:0]  bsel;
  logic [7:0]  wa;
  logic [31:0] wm;
  logic [31:0] rd;
  logic        rok;

  // Byte-lane merge for register writes
  function automatic logic [31:0] gcss_merge(input logic [31:0] o,
                                             input logic [31:0] w,
                                             input logic [3:0]  b);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (b[i]) begin
        r[i*8 +: 8] = w[i*8 +: 8];
      end
    end
    return r;
  endfunction : gcss_merge

  // Source seen by one control block for a given dynamic select
  function automatic logic gcss_src(input logic [NC_W-1:0] c,
                                    input logic [1:0]      s,
                                    input logic [3:0]      pn,
                                    input logic [2:0]      pl,
                                    input logic [3:0]      dp,
                                    input logic [3:0]      it);
    logic r;
    r = 1'b0;
    unique case (c[NC_MODE +: 2])
      MODE_DUAL:     r = dp[c[NC_DP +: 2]];
      MODE_INTERNAL: r = it[c[NC_INT +: 2]];
      MODE_OFF:      r = 1'b0;
      MODE_DYNAMIC: begin
        unique case (s)
          DSEL_PIN_A: r = pn[c[NC_PIN_A +: 2]];
          DSEL_PIN_B: r = pn[c[NC_PIN_B +: 2]];
          // PLL code three has no output behind it, so it reads low
          DSEL_PLL_A: r = (c[NC_PLL_A +: 2] == 2'h3) ? 1'b0 : pl[c[NC_PLL_A +: 2]];
          DSEL_PLL_B: r = (c[NC_PLL_B +: 2] == 2'h3) ? 1'b0 : pl[c[NC_PLL_B +: 2]];
        endcase
      end
    endcase
    return r;
  endfunction : gcss_src

  // Next state; pins sampled twice before use, first stage feeds only the second
  always_comb begin
    d    = q;
    pins = 4'h0;
    plls = 3'h0;
    dps  = 4'h0;
    ints = 4'h0;
    cur  = 1'b0;
    nxt  = 1'b0;
    sw   = 1'b0;
    gsel = 4'h0;
    bsel = 3'h0;
    wa   = 8'h00;
    wm   = 32'h0000_0000;
    rd   = 32'h0000_0000;
    rok  = 1'b1;
    d.s1 = {corner_dual_purpose_pin, dual_purpose_clock_pin,
            pll_counter_out, dedicated_clock_pin};
    d.s2 = q.s1;

    // Control blocks, one per network, each writing only its own output
    for (int n = 0; n < NETS; n++) begin
      pins = q.s2[SY_DED + (n / NETS_SIDE) * 4 +: 4];
      plls = q.s2[SY_PLL + (n / NETS_SIDE) * PLL_OUTS +: 3];
      dps  = {q.s2[SY_CORNER + (n / NETS_SIDE) * CORNER_PINS
                   + int'(q.corner[n / NETS_SIDE])],
              q.s2[SY_DP + (n / NETS_SIDE) * DP_SIDE +: 3]};
      ints = internal_clock_source[(n / NETS_SIDE) * 4 +: 4];
      cur  = gcss_src(q.net_cfg[n], q.asel[n], pins, plls, dps, ints);
      nxt  = gcss_src(q.net_cfg[n], global_source_select[n*2 +: 2],
                      pins, plls, dps, ints);
      // Changes land only while output and new source are both low
      if (!q.gnet[n] && !nxt) begin
        d.on[n]   = global_clock_enable[n];
        d.asel[n] = global_source_select[n*2 +: 2];
        d.gnet[n] = 1'b0;
      end else begin
        d.gnet[n] = q.on[n] & cur;
      end
    end

    // Reference switch per PLL, between the first two pins of its side
    for (int p = 0; p < PLLS; p++) begin
      sw = q.pll[p*2 + PC_MANUAL] ? pll_reference_switch[p]
                                  : q.pll[p*2 + PC_STATIC];
      d.pll_ref[p] = sw ? q.s2[SY_DED + p*4 + 1] : q.s2[SY_DED + p*4];
    end

    // Regional six-bit buses picked from the global networks
    for (int r = 0; r < REGIONS; r++) begin
      for (int k = 0; k < REGION_W; k++) begin
        gsel = q.region[r][k*4 +: 4];
        d.rbus[r][k] = q.gnet[gsel];
      end
    end

    // Two block clocks from the six row clocks; codes above five give low
    for (int j = 0; j < BLOCK_CLKS; j++) begin
      bsel = q.block_pick[j*BK_W +: BK_W];
      d.bclk[j] = (bsel < 3'h6) ? q.rbus[1][bsel] : 1'b0;
    end

    // Write channel: address and data taken in either order
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end
    if (s_axi_awvalid && s_axi_awready) begin
      d.aw_have = 1'b1;
      d.awaddr  = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      d.w_have = 1'b1;
      d.wdata  = s_axi_wdata;
      d.wstrb  = s_axi_wstrb;
    end
    if (d.aw_have && d.w_have) begin
      d.aw_have = 1'b0;
      d.w_have  = 1'b0;
      d.bvalid  = 1'b1;
      d.bresp   = RESP_OKAY;
      wa        = {d.awaddr[7:2], 2'b00};
      // Static settings refuse writes once user mode starts
      if (user_mode && wa < STATUS_ON) begin
        d.bresp = RESP_SLVERR;
      end else if (wa < CORNER_CFG) begin
        wm = gcss_merge({18'h0, q.net_cfg[wa[5:2]]}, d.wdata, d.wstrb);
        d.net_cfg[wa[5:2]] = wm[NC_W-1:0];
      end else if (wa == CORNER_CFG) begin
        wm = gcss_merge({28'h0, q.corner}, d.wdata, d.wstrb);
        d.corner = wm[3:0];
      end else if (wa == PLL_CFG) begin
        wm = gcss_merge({24'h0, q.pll}, d.wdata, d.wstrb);
        d.pll = wm[7:0];
      end else if (wa < BLOCK_CFG) begin
        wm = gcss_merge({8'h0, q.region[wa[3:2] - 2'h2]}, d.wdata, d.wstrb);
        d.region[wa[3:2] - 2'h2] = wm[23:0];
      end else if (wa == BLOCK_CFG) begin
        wm = gcss_merge({26'h0, q.block_pick}, d.wdata, d.wstrb);
        d.block_pick = wm[5:0];
      end else begin
        d.bresp = RESP_SLVERR;
      end
    end

    // Read channel: one outstanding, answered the cycle after the address
    if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      wa = {s_axi_araddr[7:2], 2'b00};
      if (wa < CORNER_CFG) begin
        rd = {18'h0, q.net_cfg[wa[5:2]]};
      end else if (wa == CORNER_CFG) begin
        rd = {28'h0, q.corner};
      end else if (wa == PLL_CFG) begin
        rd = {24'h0, q.pll};
      end else if (wa < BLOCK_CFG) begin
        rd = {8'h0, q.region[wa[3:2] - 2'h2]};
      end else if (wa == BLOCK_CFG) begin
        rd = {26'h0, q.block_pick};
      end else if (wa == STATUS_ON) begin
        rd = {15'h0, user_mode, q.on};
      end else if (wa == STATUS_SEL) begin
        rd = q.asel;
      end else begin
        rok = 1'b0;
      end
      d.rvalid = 1'b1;
      d.rdata  = rd;
      d.rresp  = rok ? RESP_OKAY : RESP_SLVERR;
    end
  end

  // State register; synchronous reset to fixed constants
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q            <= '0;
      q.net_cfg    <= {NETS{NET_CFG_RST}};
      q.corner     <= CORNER_RST;
      q.pll        <= PLL_RST;
      q.region     <= {REGIONS{REGION_RST}};
      q.block_pick <= BLOCK_RST;
    end else begin
      q <= d;
    end
  end

  // Handshake outputs held off while a response is pending
  assign s_axi_awready = !q.aw_have && !q.bvalid;
  assign s_axi_wready  = !q.w_have && !q.bvalid;
  assign s_axi_arready = !q.rvalid;

  // Registered outputs
  assign s_axi_bvalid             = q.bvalid;
  assign s_axi_bresp              = q.bresp;
  assign s_axi_rvalid             = q.rvalid;
  assign s_axi_rdata              = q.rdata;
  assign s_axi_rresp              = q.rresp;
  assign global_clock_net         = q.gnet;
  assign pll_reference_clock      = q.pll_ref;
  assign region_column_io_element = q.rbus[0];
  assign region_row               = q.rbus[1];
  assign region_row_io_element    = q.rbus[2];
  assign logic_array_block_clock  = q.bclk;
  assign general_pin_input        = q.s2[SY_DED +: 16];

endmodule : gcss_top

// ===== tb/gcss_source_model.sv
// Far-side model of the pins, PLL counter outputs and internal clock sources
`timescale 1ns/1ns
module gcss_source_model (
  // Clock
  input  wire logic        aclk,
  // Clock sources
  output logic      [15:0] dedicated_clock_pin,
  output logic      [11:0] pll_counter_out,
  output logic      [11:0] dual_purpose_clock_pin,
  output logic      [7:0]  corner_dual_purpose_pin,
  output logic      [15:0] internal_clock_source
);
  logic [7:0] div_q = 8'h00;

  // Free divider; every half period lasts two cycles or more, so no source glitches
  always_ff @(posedge aclk) begin
    div_q <= div_q + 8'h01;
  end

  // Pins, PLL outputs and internal sources change rate with position on a side; dual-purpose pins share one rate, corner pins another
  for (genvar i = 0; i < 16; i++) begin : g_side
    assign dedicated_clock_pin[i]   = div_q[1 + i % 4];
    assign internal_clock_source[i] = div_q[2 + i % 4];
  end
  for (genvar j = 0; j < 12; j++) begin : g_pll
    assign pll_counter_out[j]        = div_q[3 + j % 3];
    assign dual_purpose_clock_pin[j] = div_q[5];
  end
  assign corner_dual_purpose_pin = {8{div_q[6]}};
endmodule : gcss_source_model

// ===== tb/gcss_monitor.sv
// Register bus and clock gating checks for the global clock source select block
`timescale 1ns/1ns
module gcss_monitor
  import gcss_pkg::*;
(
  // Clock, reset and mode
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        user_mode,
  input  wire logic [15:0] global_clock_net,
  // AXI4-Lite
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  input  wire logic        s_axi_awready,
  input  wire logic        s_axi_wvalid,
  input  wire logic        s_axi_wready,
  input  wire logic [1:0]  s_axi_bresp,
  input  wire logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp,
  input  wire logic        s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic wboth;

  // Address and data taken on one edge; the bench always offers them together
  assign wboth = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;

  write_answer_a: assert property (wboth |=> s_axi_bvalid)
    else $error("write response late");
  static_lock_a: assert property (wboth && user_mode && s_axi_awaddr < 8'h58
    |=> s_axi_bresp == RESP_SLVERR) else $error("static write accepted in user mode");
  wresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  unmapped_read_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr >= 8'h60
    |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped read");
  write_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while busy");
  read_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
  net_pulse_a: assert property ($rose(global_clock_net[0]) |=> global_clock_net[0])
    else $error("shortened network pulse");
endmodule : gcss_monitor

bind gcss_top gcss_monitor gcss_monitor_i (.aclk, .aresetn, .user_mode, .global_clock_net,
  .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

// ===== tb/testbench.sv
// Self-checking bench for the global clock source select block
`timescale 1ns/1ns
module testbench
  import gcss_pkg::*;
();
  logic        aclk = 1'b0;
  logic        aresetn, user_mode, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, logic_array_block_clock, code;
  logic [3:0]  pll_reference_switch, pll_reference_clock, s_axi_wstrb;
  logic [5:0]  region_column_io_element, region_row, region_row_io_element;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, corner_dual_purpose_pin;
  logic [11:0] pll_counter_out, dual_purpose_clock_pin;
  logic [15:0] dedicated_clock_pin, internal_clock_source, global_clock_enable;
  logic [15:0] global_clock_net, general_pin_input;
  logic [31:0] global_source_select, s_axi_wdata, s_axi_rdata, r;
  logic [34:0] e;
  logic [34:0] exp_q[$];
  logic [30:0] obs, prv;
  int          num_errors = 0, checked = 0, seed = 15, unk = 0, rises[31];

  // Watched clocks: nets, row bus, block clocks, PLL references, one plain pin, two regions
  assign obs = {region_row_io_element[0], region_column_io_element[0], general_pin_input[1],
                pll_reference_clock, logic_array_block_clock,
                region_row, global_clock_net};

  gcss_source_model gcss_source_model_i (.aclk, .dedicated_clock_pin, .pll_counter_out,
    .dual_purpose_clock_pin, .corner_dual_purpose_pin, .internal_clock_source);
  gcss_top gcss_top_i (.aclk, .aresetn, .dedicated_clock_pin, .pll_counter_out,
    .dual_purpose_clock_pin, .corner_dual_purpose_pin, .internal_clock_source,
    .global_source_select, .global_clock_enable, .pll_reference_switch, .user_mode,
    .global_clock_net, .pll_reference_clock, .region_column_io_element, .region_row,
    .region_row_io_element, .logic_array_block_clock, .general_pin_input, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

  // 125 MHz clock
  always #4 aclk = ~aclk;

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] want);
    checked++;
    if (seen !== want) begin
      num_errors++;
      $display("[ERR] %s expected %0h seen %0h", nm, want, seen);
    end
  endtask : check

  task automatic end_of_test();
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_of_test

  // One transfer; ready handshakes sampled at the falling edge, acted on at the next rise
  task automatic axi(input bit rd, input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] er, input logic [31:0] ed);
    bit pa, pr, up, ga, gw, gr;
    int n;
    exp_q.push_back({rd, er, ed});
    pa = 1'b1;
    pr = 1'b1;
    up = 1'b0;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    s_axi_arvalid <= rd;
    s_axi_awvalid <= !rd;
    s_axi_wvalid <= !rd;
    while ((pa || pr) && n < 100) begin
      @(negedge aclk);
      ga = (s_axi_arvalid && s_axi_arready) || (s_axi_awvalid && s_axi_awready);
      gw = s_axi_wvalid && s_axi_wready;
      gr = (s_axi_rvalid && s_axi_rready) || (s_axi_bvalid && s_axi_bready);
      @(posedge aclk);
      if (ga) begin
        pa = 1'b0;
        s_axi_arvalid <= 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (gw)
        s_axi_wvalid <= 1'b0;
      if (gr) begin
        pr = 1'b0;
        s_axi_rready <= 1'b0;
        s_axi_bready <= 1'b0;
      end else if (!up && $random(seed) % 2 == 0) begin
        up = 1'b1;
        s_axi_rready <= rd;
        s_axi_bready <= !rd;
      end
      n++;
    end
    if (n >= 100) begin
      num_errors++;
      $display("[ERR] handshake expected %0d seen %0d", 99, n);
    end
  endtask : axi

  // Settle past a clean gating point, then count rising edges over 128 cycles
  task automatic run();
    foreach (rises[i]) rises[i] = 0;
    repeat (80) @(negedge aclk);
    prv = obs;
    repeat (128) begin
      @(negedge aclk);
      for (int i = 0; i < 31; i++) rises[i] += int'(obs[i] && !prv[i]);
      unk += int'($isunknown(obs));
      prv = obs;
    end
  endtask : run

  // Oldest note is matched against each response handshake
  always @(negedge aclk) begin
    if ((s_axi_bvalid && s_axi_bready) || (s_axi_rvalid && s_axi_rready)) begin
      e = exp_q.pop_front();
      check("resp", e[34] ? s_axi_rresp : s_axi_bresp, e[33:32]);
      if (e[34])
        check("rdata", s_axi_rdata, e[31:0]);
    end
  end

  // Hang guard, well past the expected run length
  initial begin
    #160000;
    num_errors++;
    $display("[ERR] watchdog expected finish seen timeout");
    end_of_test();
  end

  // Main sequence
  initial begin
    {aresetn, user_mode, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {global_source_select, pll_reference_switch} = '0;
    s_axi_wstrb = 4'hF;
    global_clock_enable = 16'hFFFF;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    axi(1, 8'h00, 32'h0, RESP_OKAY, 32'h0);
    axi(1, 8'h48, 32'h0, RESP_OKAY, 32'h00543210);
    axi(1, 8'h54, 32'h0, RESP_OKAY, 32'h00000008);
    axi(1, 8'h60, 32'h0, RESP_SLVERR, 32'h0);
    axi(0, 8'h58, 32'h1, RESP_SLVERR, 32'h0);
    axi(0, 8'h00, 32'h44, RESP_OKAY, 32'h0);
    axi(0, 8'h04, 32'h1000, RESP_OKAY, 32'h0);
    axi(0, 8'h08, 32'h2000, RESP_OKAY, 32'h0);
    axi(0, 8'h0C, 32'h3000, RESP_OKAY, 32'h0);
    axi(0, 8'h18, 32'h1300, RESP_OKAY, 32'h0);
    axi(0, 8'h44, 32'h2, RESP_OKAY, 32'h0);
    user_mode <= 1'b1;
    axi(0, 8'h00, 32'h0, RESP_SLVERR, 32'h0);
    axi(1, 8'h00, 32'h0, RESP_OKAY, 32'h44);
    $display("test registers done");
    global_source_select[11:10] <= DSEL_PLL_A;
    pll_reference_switch <= 4'h1;
    r = $random(seed);
    for (int i = 0; i < 4; i++) begin
      code = 2'(i + r);
      global_source_select[1:0] <= code;
      run();
      check("net0", rises[0], 32 >> code);
      check("row0", rises[16], 32 >> code);
      check("lab0", rises[22], 32 >> code);
      check("col0", rises[29], 32 >> code);
      check("rowio0", rises[30], 32 >> code);
    end
    check("net1", rises[1], 2);
    check("net2", rises[2], 16);
    check("net3", rises[3], 0);
    check("net4", rises[4], 32);
    check("net5", rises[5], 8);
    check("net6", rises[6], 1);
    check("pllref1", rises[25], 32);
    check("pllref", rises[24], 16);
    check("plainpin", rises[28], 16);
    $display("test select done");
    global_clock_enable[0] <= 1'b0;
    run();
    check("off", rises[0], 0);
    global_clock_enable[0] <= 1'b1;
    run();
    check("on", rises[0], 32 >> code);
    $display("test enable done");
    user_mode <= 1'b0;
    axi(0, 8'h4C, 32'h00543215, RESP_OKAY, 32'h0);
    axi(0, 8'h54, 32'h01, RESP_OKAY, 32'h0);
    run();
    check("row0", rises[16], 8);
    check("row1", rises[17], 2);
    check("lab0", rises[22], 2);
    check("lab1", rises[23], 8);
    $display("test regions done");
    check("known", unk, 0);
    end_of_test();
  end
endmodule : testbench
